// ==== verilog/itf_pkg.sv ====
// Package of codes, widths and reset values for the input terminal function decoder
package itf_pkg;
    localparam int NUM_TERM     = 8;
    localparam int CODE_W       = 7;
    localparam int NUM_SW_REF   = 3;
    localparam int SYNC_STAGES  = 2;
    localparam int DATA_W       = 16;

    typedef logic [CODE_W-1:0] itf_code_t;

    localparam itf_code_t FN_CMD_KEYPAD   = 7'h24;
    localparam itf_code_t FN_CMD_TERMINAL = 7'h25;
    localparam itf_code_t FN_CMD_COMM     = 7'h26;
    localparam itf_code_t FN_PRE_EXCITE   = 7'h27;
    localparam itf_code_t FN_ENERGY_CLEAR = 7'h28;
    localparam itf_code_t FN_ENERGY_HOLD  = 7'h29;
    localparam itf_code_t FN_TORQUE_KEYPD = 7'h2A;
    localparam itf_code_t FN_POS_REF_PT   = 7'h2B;
    localparam itf_code_t FN_SPINDLE_ZERO = 7'h2D;
    localparam itf_code_t FN_POS_SPEED    = 7'h33;
    localparam itf_code_t FN_PULSE_OFF    = 7'h34;
    localparam itf_code_t FN_DEV_CLEAR    = 7'h35;
    localparam itf_code_t FN_EMERG_STOP   = 7'h38;
    localparam itf_code_t FN_OVERTEMP     = 7'h39;
    localparam itf_code_t FN_TO_SVM       = 7'h3B;
    localparam itf_code_t FN_TO_CLV       = 7'h3C;
    localparam itf_code_t FN_SERVO_EN     = 7'h3F;
    localparam itf_code_t FN_FWD_LIMIT    = 7'h40;
    localparam itf_code_t FN_REV_LIMIT    = 7'h41;
    localparam itf_code_t FN_POS_CNT_CLR  = 7'h42;
    localparam itf_code_t FN_PULSE_INC    = 7'h43;
    localparam itf_code_t FN_SUPERIMPOSE  = 7'h44;
    localparam itf_code_t FN_PULSE_DEC    = 7'h45;
    localparam itf_code_t FN_GEAR_SEL     = 7'h46;
    localparam itf_code_t FN_MASTER       = 7'h47;
    localparam itf_code_t FN_SLAVE        = 7'h48;

    typedef enum logic [1:0] {
        ITF_SRC_KEYPAD,
        ITF_SRC_TERMINAL,
        ITF_SRC_COMM
    } itf_src_t;

    localparam logic RST_CLV_MODE    = 1'b0;
    localparam logic RST_MASTER_ROLE = 1'b0;
    localparam logic [DATA_W:0] RST_PULSE_RATE = 17'h00000;
endpackage

// ==== verilog/itf_sync.sv ====
// Two-stage synchroniser for the terminal pins
`timescale 1ns/1ps
module itf_sync
(
    // Clock and reset
    input  wire logic                          ref_clk_i,
    input  wire logic                          rst_i,
    // Pins and synchronised levels
    input  wire logic [itf_pkg::NUM_TERM-1:0]  pin_i,
    output logic      [itf_pkg::NUM_TERM-1:0]  level_o
);
    typedef struct packed {
        logic [itf_pkg::NUM_TERM-1:0] meta;
        logic [itf_pkg::NUM_TERM-1:0] level;
    } itf_sync_state_t;

    itf_sync_state_t st_reg;
    itf_sync_state_t st_next;

    // Only the second stage feeds logic
    always_comb
    begin
        st_next       = st_reg;
        st_next.meta  = pin_i;
        st_next.level = st_reg.meta;
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign level_o = st_reg.level;
endmodule

// ==== verilog/itf_decoder.sv ====
// Decoder that turns terminal function codes 36 to 72 into drive control requests
//
// Contract
// - Function 36 active forces run-command source to keypad.
// - Function 37 active forces run-command source to terminals.
// - Function 38 active forces run-command source to communication.
// - Override released restores the previously configured run-command source.
// - Function 39 keeps motor pre-excitation running while active.
// - Function 40 going active clears the energy count.
// - Function 41 active freezes the energy count.
// - Function 42 active takes upper torque limit from keypad.
// - Function 43 honoured only on first three switch inputs.
// - Function 45 going active triggers spindle zeroing.
// - Function 51 selects position or speed control by its level.
// - Function 52 active ignores the pulse reference input.
// - Function 53 active clears position loop input deviation.
// - Function 56 commands emergency stop with emergency deceleration time.
// - Function 57 is a motor over-temperature fault and stops the motor.
// - Functions 59/60 select open-loop or closed-loop mode, only while stopped.
// - Function 63 with servo enabled enters zero-servo without start command.
// - Functions 64/65 apply forward and reverse maximum-frequency limits.
// - Function 66 active clears the position counting value.
// - With 68 active, 67/69 raise or lower pulse input at set speed.
// - Function 70 active selects the second electronic-gear numerator.
// - While stopped, 71 selects master role and 72 slave role.
`timescale 1ns/1ps
module itf_decoder
(
    // Clock and reset
    input  wire logic                                      ref_clk_i,
    input  wire logic                                      rst_i,
    // Terminal pins and per-terminal function codes
    input  wire logic [itf_pkg::NUM_TERM-1:0]              term_pin_i,
    input  wire logic [itf_pkg::NUM_TERM-1:0][itf_pkg::CODE_W-1:0] term_code_i,
    // Drive configuration and state
    input  wire logic [1:0]                                cmd_src_cfg_i,
    input  wire logic                                      stopped_i,
    input  wire logic                                      servo_enable_cfg_i,
    input  wire logic [itf_pkg::DATA_W-1:0]                emergency_decel_time_i,
    input  wire logic [itf_pkg::DATA_W-1:0]                superimpose_pulse_speed_i,
    input  wire logic [itf_pkg::DATA_W-1:0]                first_gear_numerator_i,
    input  wire logic [itf_pkg::DATA_W-1:0]                second_gear_numerator_i,
    // Command channel and motor requests
    output logic      [1:0]                                cmd_src_o,
    output logic                                           pre_excite_o,
    output logic                                           energy_clear_o,
    output logic                                           energy_hold_o,
    output logic                                           torque_limit_keypad_o,
    output logic                                           emergency_stop_o,
    output logic      [itf_pkg::DATA_W-1:0]                emergency_decel_time_o,
    output logic                                           overtemp_fault_o,
    output logic                                           motor_stop_o,
    output logic                                           fwd_max_limit_o,
    output logic                                           rev_max_limit_o,
    // Position and spindle requests
    output logic                                           pos_ref_point_o,
    output logic                                           spindle_zero_o,
    output logic                                           position_mode_o,
    output logic                                           pulse_input_disable_o,
    output logic                                           pos_dev_clear_o,
    output logic                                           zero_servo_o,
    output logic                                           pos_count_clear_o,
    output logic signed [itf_pkg::DATA_W:0]                pulse_rate_o,
    output logic      [itf_pkg::DATA_W-1:0]                gear_numerator_o,
    // Mode state
    output logic                                           closed_loop_vector_mode_o,
    output logic                                           master_role_o
);
    typedef struct packed {
        logic [1:0]                   cmd_src;
        logic                         pre_excite;
        logic                         energy_clear;
        logic                         energy_hold;
        logic                         torque_keypad;
        logic                         estop;
        logic [itf_pkg::DATA_W-1:0]   decel_time;
        logic                         overtemp;
        logic                         motor_stop;
        logic                         fwd_limit;
        logic                         rev_limit;
        logic                         ref_point;
        logic                         spindle_zero;
        logic                         pos_mode;
        logic                         pulse_off;
        logic                         dev_clear;
        logic                         zero_servo;
        logic                         cnt_clear;
        logic [itf_pkg::DATA_W:0]     pulse_rate;
        logic [itf_pkg::DATA_W-1:0]   gear_num;
        logic                         clv_mode;
        logic                         master;
        logic                         clear_prev;
        logic                         zero_prev;
    } itf_state_t;

    itf_state_t                   st_reg;
    itf_state_t                   st_next;
    logic [itf_pkg::NUM_TERM-1:0] act;

    // Decode of one function over the first n terminals
    function automatic logic fn_active(
        input logic [itf_pkg::NUM_TERM-1:0]                     a,
        input logic [itf_pkg::NUM_TERM-1:0][itf_pkg::CODE_W-1:0] c,
        input logic [itf_pkg::CODE_W-1:0]                       f,
        input int                                               n
    );
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < itf_pkg::NUM_TERM; i++)
        begin
            if (i < n && a[i] && c[i] == f)
            begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    itf_sync u_sync
    (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .pin_i     (term_pin_i),
        .level_o   (act)
    );

    logic f_kpd, f_trm, f_com, f_pre, f_eclr, f_ehold, f_tq, f_ref, f_spz;
    logic f_pos, f_poff, f_dev, f_est, f_ot, f_svm, f_clv, f_servo;
    logic f_fwd, f_rev, f_cnt, f_inc, f_sup, f_dec, f_gear, f_mst, f_slv;

    // Per-terminal code routing
    always_comb
    begin
        f_kpd   = fn_active(act, term_code_i, itf_pkg::FN_CMD_KEYPAD,
                            itf_pkg::NUM_TERM);
        f_trm   = fn_active(act, term_code_i, itf_pkg::FN_CMD_TERMINAL, itf_pkg::NUM_TERM);
        f_com   = fn_active(act, term_code_i, itf_pkg::FN_CMD_COMM,     itf_pkg::NUM_TERM);
        f_pre   = fn_active(act, term_code_i, itf_pkg::FN_PRE_EXCITE,   itf_pkg::NUM_TERM);
        f_eclr  = fn_active(act, term_code_i, itf_pkg::FN_ENERGY_CLEAR, itf_pkg::NUM_TERM);
        f_ehold = fn_active(act, term_code_i, itf_pkg::FN_ENERGY_HOLD,  itf_pkg::NUM_TERM);
        f_tq    = fn_active(act, term_code_i, itf_pkg::FN_TORQUE_KEYPD, itf_pkg::NUM_TERM);
        f_ref   = fn_active(act, term_code_i, itf_pkg::FN_POS_REF_PT,
                            itf_pkg::NUM_SW_REF);
        f_spz   = fn_active(act, term_code_i, itf_pkg::FN_SPINDLE_ZERO, itf_pkg::NUM_TERM);
        f_pos   = fn_active(act, term_code_i, itf_pkg::FN_POS_SPEED,    itf_pkg::NUM_TERM);
        f_poff  = fn_active(act, term_code_i, itf_pkg::FN_PULSE_OFF,    itf_pkg::NUM_TERM);
        f_dev   = fn_active(act, term_code_i, itf_pkg::FN_DEV_CLEAR,    itf_pkg::NUM_TERM);
        f_est   = fn_active(act, term_code_i, itf_pkg::FN_EMERG_STOP,   itf_pkg::NUM_TERM);
        f_ot    = fn_active(act, term_code_i, itf_pkg::FN_OVERTEMP,     itf_pkg::NUM_TERM);
        f_svm   = fn_active(act, term_code_i, itf_pkg::FN_TO_SVM,       itf_pkg::NUM_TERM);
        f_clv   = fn_active(act, term_code_i, itf_pkg::FN_TO_CLV,       itf_pkg::NUM_TERM);
        f_servo = fn_active(act, term_code_i, itf_pkg::FN_SERVO_EN,     itf_pkg::NUM_TERM);
        f_fwd   = fn_active(act, term_code_i, itf_pkg::FN_FWD_LIMIT,    itf_pkg::NUM_TERM);
        f_rev   = fn_active(act, term_code_i, itf_pkg::FN_REV_LIMIT,    itf_pkg::NUM_TERM);
        f_cnt   = fn_active(act, term_code_i, itf_pkg::FN_POS_CNT_CLR,  itf_pkg::NUM_TERM);
        f_inc   = fn_active(act, term_code_i, itf_pkg::FN_PULSE_INC,    itf_pkg::NUM_TERM);
        f_sup   = fn_active(act, term_code_i, itf_pkg::FN_SUPERIMPOSE,  itf_pkg::NUM_TERM);
        f_dec   = fn_active(act, term_code_i, itf_pkg::FN_PULSE_DEC,    itf_pkg::NUM_TERM);
        f_gear  = fn_active(act, term_code_i, itf_pkg::FN_GEAR_SEL,     itf_pkg::NUM_TERM);
        f_mst   = fn_active(act, term_code_i, itf_pkg::FN_MASTER,       itf_pkg::NUM_TERM);
        f_slv   = fn_active(act, term_code_i, itf_pkg::FN_SLAVE,        itf_pkg::NUM_TERM);
    end

    // Next state
    always_comb
    begin
        st_next = st_reg;
        // Override priority keypad, terminal, communication
        if (f_kpd)
        begin
            st_next.cmd_src = 2'(itf_pkg::ITF_SRC_KEYPAD);
        end
        else if (f_trm)
        begin
            st_next.cmd_src = 2'(itf_pkg::ITF_SRC_TERMINAL);
        end
        else if (f_com)
        begin
            st_next.cmd_src = 2'(itf_pkg::ITF_SRC_COMM);
        end
        else
        begin
            st_next.cmd_src = cmd_src_cfg_i;
        end
        st_next.pre_excite    = f_pre;
        st_next.energy_clear  = f_eclr && !st_reg.clear_prev;
        st_next.clear_prev    = f_eclr;
        st_next.energy_hold   = f_ehold;
        st_next.torque_keypad = f_tq;
        st_next.ref_point     = f_ref;
        st_next.spindle_zero  = f_spz && !st_reg.zero_prev;
        st_next.zero_prev     = f_spz;
        st_next.pos_mode      = f_pos;
        st_next.pulse_off     = f_poff;
        st_next.dev_clear     = f_dev;
        st_next.estop         = f_est;
        st_next.decel_time    = emergency_decel_time_i;
        st_next.overtemp      = f_ot;
        st_next.motor_stop    = f_est || f_ot;
        // Control mode changes only at standstill
        if (stopped_i && f_clv && !f_svm)
        begin
            st_next.clv_mode = 1'b1;
        end
        else if (stopped_i && f_svm && !f_clv)
        begin
            st_next.clv_mode = 1'b0;
        end
        st_next.zero_servo    = servo_enable_cfg_i && f_servo;
        st_next.fwd_limit     = f_fwd;
        st_next.rev_limit     = f_rev;
        st_next.cnt_clear     = f_cnt;
        // Superimposed pulse rate, opposing requests cancel
        if (f_sup && f_inc && !f_dec)
        begin
            st_next.pulse_rate = {1'b0, superimpose_pulse_speed_i};
        end
        else if (f_sup && f_dec && !f_inc)
        begin
            st_next.pulse_rate = (itf_pkg::DATA_W+1)'(-{1'b0, superimpose_pulse_speed_i});
        end
        else
        begin
            st_next.pulse_rate = itf_pkg::RST_PULSE_RATE;
        end
        st_next.gear_num = f_gear ? second_gear_numerator_i : first_gear_numerator_i;
        // Role changes only at standstill
        if (stopped_i && f_mst && !f_slv)
        begin
            st_next.master = 1'b1;
        end
        else if (stopped_i && f_slv && !f_mst)
        begin
            st_next.master = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_reg            <= '0;
            st_reg.clv_mode   <= itf_pkg::RST_CLV_MODE;
            st_reg.master     <= itf_pkg::RST_MASTER_ROLE;
            st_reg.pulse_rate <= itf_pkg::RST_PULSE_RATE;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign cmd_src_o                 = st_reg.cmd_src;
    assign pre_excite_o              = st_reg.pre_excite;
    assign energy_clear_o            = st_reg.energy_clear;
    assign energy_hold_o             = st_reg.energy_hold;
    assign torque_limit_keypad_o     = st_reg.torque_keypad;
    assign emergency_stop_o          = st_reg.estop;
    assign emergency_decel_time_o    = st_reg.decel_time;
    assign overtemp_fault_o          = st_reg.overtemp;
    assign motor_stop_o              = st_reg.motor_stop;
    assign fwd_max_limit_o           = st_reg.fwd_limit;
    assign rev_max_limit_o           = st_reg.rev_limit;
    assign pos_ref_point_o           = st_reg.ref_point;
    assign spindle_zero_o            = st_reg.spindle_zero;
    assign position_mode_o           = st_reg.pos_mode;
    assign pulse_input_disable_o     = st_reg.pulse_off;
    assign pos_dev_clear_o           = st_reg.dev_clear;
    assign zero_servo_o              = st_reg.zero_servo;
    assign pos_count_clear_o         = st_reg.cnt_clear;
    assign pulse_rate_o              = st_reg.pulse_rate;
    assign gear_numerator_o          = st_reg.gear_num;
    assign closed_loop_vector_mode_o = st_reg.clv_mode;
    assign master_role_o             = st_reg.master;

    // Checks
    property p_keypad;
        @(posedge ref_clk_i) disable iff (rst_i)
        f_kpd |=> cmd_src_o == 2'(itf_pkg::ITF_SRC_KEYPAD);
    endproperty
    a_keypad: assert property (p_keypad) else $error("keypad override not applied");

    property p_terminal;
        @(posedge ref_clk_i) disable iff (rst_i)
        (f_trm && !f_kpd) |=> cmd_src_o == 2'(itf_pkg::ITF_SRC_TERMINAL);
    endproperty
    a_terminal: assert property (p_terminal) else $error("terminal override missed");

    property p_comm;
        @(posedge ref_clk_i) disable iff (rst_i)
        (f_com && !f_kpd && !f_trm) |=> cmd_src_o == 2'(itf_pkg::ITF_SRC_COMM);
    endproperty
    a_comm: assert property (p_comm) else $error("comm override not applied");

    property p_restore;
        @(posedge ref_clk_i) disable iff (rst_i)
        (!f_kpd && !f_trm && !f_com) |=> cmd_src_o == $past(cmd_src_cfg_i);
    endproperty
    a_restore: assert property (p_restore) else $error("command source not restored");

    property p_clear_pulse;
        @(posedge ref_clk_i) disable iff (rst_i)
        energy_clear_o |=> !energy_clear_o;
    endproperty
    a_clear_pulse: assert property (p_clear_pulse) else $error("clear pulse too long");

    property p_clear_rise;
        @(posedge ref_clk_i) disable iff (rst_i)
        (!f_eclr ##1 f_eclr) |=> energy_clear_o;
    endproperty
    a_clear_rise: assert property (p_clear_rise) else $error("energy clear missed");

    property p_ref_point;
        @(posedge ref_clk_i) disable iff (rst_i)
        pos_ref_point_o |-> $past(act[0] && term_code_i[0] == itf_pkg::FN_POS_REF_PT
            || act[1] && term_code_i[1] == itf_pkg::FN_POS_REF_PT
            || act[2] && term_code_i[2] == itf_pkg::FN_POS_REF_PT);
    endproperty
    a_ref_point: assert property (p_ref_point) else $error("bad ref point terminal");

    property p_stop;
        @(posedge ref_clk_i) disable iff (rst_i)
        (f_est || f_ot) |=> motor_stop_o;
    endproperty
    a_stop: assert property (p_stop) else $error("motor stop not requested");

    property p_mode_hold;
        @(posedge ref_clk_i) disable iff (rst_i)
        !stopped_i |=> $stable(closed_loop_vector_mode_o);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed in run");

    property p_servo;
        @(posedge ref_clk_i) disable iff (rst_i)
        zero_servo_o |-> $past(servo_enable_cfg_i && f_servo);
    endproperty
    a_servo: assert property (p_servo) else $error("zero servo without enable");

    property p_pulse_gate;
        @(posedge ref_clk_i) disable iff (rst_i)
        !f_sup |=> pulse_rate_o == 17'sh00000;
    endproperty
    a_pulse_gate: assert property (p_pulse_gate) else $error("rate while gated");

    property p_role_hold;
        @(posedge ref_clk_i) disable iff (rst_i)
        !stopped_i |=> $stable(master_role_o);
    endproperty
    a_role_hold: assert property (p_role_hold) else $error("role changed in run");

    c_override: cover property (@(posedge ref_clk_i) disable iff (rst_i) f_kpd ##1 !f_kpd);
    c_mode_sw:  cover property (@(posedge ref_clk_i) disable iff (rst_i)
        $rose(closed_loop_vector_mode_o));
    c_pulse_up: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        f_sup && f_inc ##1 pulse_rate_o != 17'sh00000);
    c_estop:    cover property (@(posedge ref_clk_i) disable iff (rst_i) $rose(emergency_stop_o));
endmodule

// ==== verification/itf_switch_bank.sv ====
// Model of the external switch contacts wired to the terminal pins
`timescale 1ns/1ps
module itf_switch_bank
(
    // Clock
    input  wire logic                         ref_clk_i,
    // Requested closures and resulting pin levels
    input  wire logic [itf_pkg::NUM_TERM-1:0] close_i,
    output logic      [itf_pkg::NUM_TERM-1:0] pin_o
);
    // Open contacts read low through the pull-down; closures land on a clock
    always_ff @(posedge ref_clk_i)
    begin
        pin_o <= close_i;
    end
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench for the terminal function decoder
`timescale 1ns/1ps
module tb_top;
    logic                   ref_clk_i, rst_i, stopped_i, servo_enable_cfg_i;
    logic [7:0]             close_q, term_pin_i;
    logic [7:0][6:0]        term_code_i;
    logic [1:0]             cmd_src_cfg_i, cmd_src_o;
    logic [15:0]            emergency_decel_time_i, superimpose_pulse_speed_i;
    logic [15:0]            first_gear_numerator_i, second_gear_numerator_i;
    logic [15:0]            emergency_decel_time_o, gear_numerator_o;
    logic signed [16:0]     pulse_rate_o;
    logic                   pre_excite_o, energy_clear_o, energy_hold_o, torque_limit_keypad_o;
    logic                   emergency_stop_o, overtemp_fault_o, motor_stop_o, fwd_max_limit_o;
    logic                   rev_max_limit_o, pos_ref_point_o, spindle_zero_o, position_mode_o;
    logic                   pulse_input_disable_o, pos_dev_clear_o, zero_servo_o;
    logic                   pos_count_clear_o, closed_loop_vector_mode_o, master_role_o;
    int                     n_mismatch, samples_checked, n_clr, n_spz, m_clv, m_mst;
    localparam int DIR[5][8] = '{'{36, 37, 38, 39, 40, 41, 42, 45},
        '{59, 60, 71, 72, 43, 51, 52, 53},
        '{67, 68, 69, 70, 63, 64, 65, 66}, '{43, 43, 43, 56, 57, 59, 60, 45},
        '{36, 37, 38, 36, 67, 67, 68, 69}};

    itf_switch_bank sw_u (.ref_clk_i, .close_i(close_q), .pin_o(term_pin_i));

    itf_decoder dut_u
    (
        .ref_clk_i, .rst_i, .term_pin_i, .term_code_i, .cmd_src_cfg_i, .stopped_i,
        .servo_enable_cfg_i, .emergency_decel_time_i, .superimpose_pulse_speed_i,
        .first_gear_numerator_i, .second_gear_numerator_i, .cmd_src_o, .pre_excite_o,
        .energy_clear_o, .energy_hold_o, .torque_limit_keypad_o, .emergency_stop_o,
        .emergency_decel_time_o, .overtemp_fault_o, .motor_stop_o, .fwd_max_limit_o,
        .rev_max_limit_o, .pos_ref_point_o, .spindle_zero_o, .position_mode_o,
        .pulse_input_disable_o, .pos_dev_clear_o, .zero_servo_o, .pos_count_clear_o,
        .pulse_rate_o, .gear_numerator_o, .closed_loop_vector_mode_o, .master_role_o
    );

    initial
    begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end

    // Pulse outputs are counted at every rising edge
    always @(posedge ref_clk_i)
    begin
        if (energy_clear_o === 1'b1) n_clr++;
        if (spindle_zero_o === 1'b1) n_spz++;
    end

    function automatic bit act(input int f);
        act = 1'b0;
        for (int t = 0; t < 8; t++)
            if (close_q[t] && term_code_i[t] == 7'(f) && (f != 43 || t < 3)) act = 1'b1;
    endfunction

    task automatic chk(input string n, input logic [16:0] e, input logic [16:0] g);
        samples_checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic mode_upd(input bit s);
        if (s && act(60) && !act(59)) m_clv = 1;
        if (s && act(59) && !act(60)) m_clv = 0;
        if (s && act(71) && !act(72)) m_mst = 1;
        if (s && act(72) && !act(71)) m_mst = 0;
    endtask

    task automatic apply(input logic [7:0] p);
        int c40, c45, src;
        bit o40, o45, s;
        logic [16:0] rate;
        logic [15:0] gear;
        s = 1'($urandom);
        o40 = act(40);
        o45 = act(45);
        c40 = n_clr;
        c45 = n_spz;
        mode_upd(s);
        @(posedge ref_clk_i);
        close_q <= p;
        stopped_i <= s;
        cmd_src_cfg_i <= 2'($urandom % 3);
        servo_enable_cfg_i <= 1'($urandom);
        emergency_decel_time_i <= 16'($urandom);
        superimpose_pulse_speed_i <= 16'($urandom);
        first_gear_numerator_i <= 16'($urandom);
        second_gear_numerator_i <= 16'($urandom);
        repeat (6) @(posedge ref_clk_i);
        #1;
        mode_upd(s);
        rate = (act(67) && !act(69)) ? {1'b0, superimpose_pulse_speed_i} :
               (act(69) && !act(67)) ? -{1'b0, superimpose_pulse_speed_i} : 17'h00000;
        src = act(36) ? 0 : act(37) ? 1 : act(38) ? 2 : int'(cmd_src_cfg_i);
        gear = act(70) ? second_gear_numerator_i : first_gear_numerator_i;
        chk("cmd_src", src, cmd_src_o);
        chk("pre_excite", act(39), pre_excite_o);
        chk("energy_clear", !o40 && act(40), n_clr - c40);
        chk("energy_hold", act(41), energy_hold_o);
        chk("torque_keypad", act(42), torque_limit_keypad_o);
        chk("pos_ref_point", act(43), pos_ref_point_o);
        chk("spindle_zero", !o45 && act(45), n_spz - c45);
        chk("position_mode", act(51), position_mode_o);
        chk("pulse_disable", act(52), pulse_input_disable_o);
        chk("dev_clear", act(53), pos_dev_clear_o);
        chk("emerg_stop", act(56), emergency_stop_o);
        chk("emerg_time", emergency_decel_time_i, emergency_decel_time_o);
        chk("overtemp", act(57), overtemp_fault_o);
        chk("motor_stop", act(56) || act(57), motor_stop_o);
        chk("clv_mode", m_clv, closed_loop_vector_mode_o);
        chk("zero_servo", act(63) && servo_enable_cfg_i, zero_servo_o);
        chk("fwd_limit", act(64), fwd_max_limit_o);
        chk("rev_limit", act(65), rev_max_limit_o);
        chk("pos_cnt_clear", act(66), pos_count_clear_o);
        chk("pulse_rate", act(68) ? rate : 17'h00000, pulse_rate_o);
        chk("gear", gear, gear_numerator_o);
        chk("master", m_mst, master_role_o);
    endtask

    task automatic stop_test;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge ref_clk_i);
        n_mismatch++;
        $display("[ERR] watchdog expected finish seen hang");
        stop_test();
    end

    initial
    begin
        rst_i = 1'b1;
        close_q = 8'h00;
        term_code_i = '0;
        cmd_src_cfg_i = 2'h0;
        stopped_i = 1'b0;
        servo_enable_cfg_i = 1'b0;
        emergency_decel_time_i = 16'h0000;
        superimpose_pulse_speed_i = 16'h0000;
        first_gear_numerator_i = 16'h0000;
        second_gear_numerator_i = 16'h0000;
        void'($urandom(31));
        repeat (12) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        for (int ph = 0; ph < 8; ph++)
        begin
            apply(8'h00);
            @(posedge ref_clk_i);
            for (int t = 0; t < 8; t++)
                term_code_i[t] <= (ph < 5) ? 7'(DIR[ph][t]) : 7'(36 + $urandom % 37);
            apply(8'h00);
            apply(8'hFF);
            for (int i = 0; i < 25; i++)
                apply(8'($urandom));
            $display("phase %0d done", ph);
        end
        stop_test();
    end
endmodule
